// ---- src/qdc_pkg.sv ----
// constants for the quiet decay configuration register bank
package qdc_pkg;
  // clock rate, 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // register byte addresses
  localparam logic [7:0] A_ADAPT = 8'h2F;   // supply adapt control
  localparam logic [7:0] A_RSVD  = 8'h30;   // reserved auto torque control
  localparam logic [7:0] A_MAIN  = 8'h31;   // quiet decay main control
  localparam logic [7:0] A_KP    = 8'h32;   // proportional gain
  localparam logic [7:0] A_KI    = 8'h33;   // integral gain
  localparam logic [7:0] A_DIV   = 8'h34;   // gain dividers
  localparam logic [7:0] A_THR   = 8'h35;   // exit frequency threshold
  localparam int NREG = 7;                  // registers from A_ADAPT upward
  // reset values, indexed from A_ADAPT
  localparam logic [7:0] RST_VAL [NREG] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                            8'h00, 8'h00, 8'hFF};
  // field positions
  localparam int B_ADAPT  = 6;   // supply adapt enable
  localparam int B_EN     = 0;   // quiet decay enable
  localparam int B_PWM    = 2;   // pwm rate, 2 bits
  localparam int B_SMPL   = 6;   // zero cross sample time, 2 bits
  localparam int B_KP_DIV = 0;   // proportional divider, 3 bits
  localparam int B_KI_DIV = 4;   // integral divider, 3 bits
  // zero cross sample times in ns and their cycle counts, rounded up
  localparam int SMPL_NS0 = 2000;
  localparam int SMPL_NS1 = 3000;
  localparam int SMPL_NS2 = 4000;
  localparam int SMPL_NS3 = 5000;
  localparam int SMPL_CYC0 = (SMPL_NS0 * CLK_MHZ + 999) / 1000;
  localparam int SMPL_CYC1 = (SMPL_NS1 * CLK_MHZ + 999) / 1000;
  localparam int SMPL_CYC2 = (SMPL_NS2 * CLK_MHZ + 999) / 1000;
  localparam int SMPL_CYC3 = (SMPL_NS3 * CLK_MHZ + 999) / 1000;
  // pwm rates in Hz and period lengths in cycles
  localparam int PWM_HZ0 = 25000;
  localparam int PWM_HZ1 = 33000;
  localparam int PWM_HZ2 = 42000;
  localparam int PWM_HZ3 = 50000;
  localparam int PWM_CYC0 = CLK_HZ / PWM_HZ0;
  localparam int PWM_CYC1 = CLK_HZ / PWM_HZ1;
  localparam int PWM_CYC2 = CLK_HZ / PWM_HZ2;
  localparam int PWM_CYC3 = CLK_HZ / PWM_HZ3;
  // divider codes to right shifts
  localparam logic [3:0] SH_32   = 4'h5;
  localparam logic [3:0] SH_64   = 4'h6;
  localparam logic [3:0] SH_128  = 4'h7;
  localparam logic [3:0] SH_256  = 4'h8;
  localparam logic [3:0] SH_512  = 4'h9;
  localparam logic [3:0] SH_16   = 4'h4;
  localparam logic [3:0] SH_NONE = 4'h0;
  // integrator clamp
  localparam int INTEG_MAX = 2047;
  // duty limit
  localparam int DUTY_MAX = 255;
endpackage : qdc_pkg

// ---- src/qdc_regs.sv ----
// quiet decay configuration registers with pwm, zero cross and pi loop
//
// Overview of operation
// - supply adapt bit retunes learning on supply change
// - five byte registers 0x31-0x35, all read/write
// - sample time code selects 2 to 5 us
// - pwm rate code selects 25/33/42/50 kHz
// - enable bit switches quiet decay, resets off
// - seven bit proportional gain, resets zero
// - seven bit integral gain, resets zero
// - proportional gain divided by selected factor
// - integral gain uses same divider mapping
// - leave quiet decay above frequency threshold
`timescale 1ns/1ps
`default_nettype none
module qdc_regs
(
  input  wire logic        CLK,         // 10 MHz clock
  input  wire logic        RSTN,        // synchronous reset, active low
  input  wire logic [7:0]  ADDR,        // register address
  input  wire logic [7:0]  WDATA,       // write data
  input  wire logic        WR,          // write strobe
  input  wire logic        RD,          // read strobe
  output logic      [7:0]  RDATA,       // read data, cycle after RD
  input  wire logic        SUPPLY_CHG,  // supply voltage change pulse
  input  wire logic        ZERO_CROSS,  // coil current zero cross pulse
  input  wire logic [8:0]  SINE_FREQ,   // sine frequency, 2 Hz units
  input  wire logic [7:0]  TARGET_I,    // target coil current
  input  wire logic [7:0]  SENSE_I,     // sensed coil current
  output logic             RETUNE,      // learning retune pulse
  output logic             SS_ACTIVE,   // quiet decay in force
  output logic             PWM_START,   // first cycle of pwm period
  output logic             ZC_SAMPLE,   // zero cross sampling window
  output logic      [7:0]  DUTY         // bridge duty
);
  // register storage, indexed from the adapt register upward
  logic [7:0] regs_q [qdc_pkg::NREG];
  logic [7:0] idx;                      // address offset into storage
  logic       hit;                      // address is mapped
  assign idx = ADDR - qdc_pkg::A_ADAPT;
  assign hit = (ADDR >= qdc_pkg::A_ADAPT) && (ADDR <= qdc_pkg::A_THR);

  // one write-enabled byte per register
  genvar g;
  generate
    for (g = 0; g < qdc_pkg::NREG; g++)
    begin : g_reg
      always_ff @(posedge CLK)
      begin
        if (!RSTN)
          regs_q[g] <= qdc_pkg::RST_VAL[g];
        else if (WR && hit && idx == 8'(g))
          regs_q[g] <= WDATA;
      end
    end
  endgenerate

  // read mux, unmapped addresses read zero
  logic [7:0] rdata_d;
  assign rdata_d = hit ? regs_q[idx[2:0]] : 8'h00;

  // named fields
  logic       adapt_en;     // supply adapt enable
  logic       ss_en;        // quiet decay enable
  logic [1:0] pwm_rate;     // pwm rate code
  logic [1:0] smpl_sel;     // sample time code
  logic [6:0] kp;           // proportional gain
  logic [6:0] ki;           // integral gain
  logic [2:0] kp_div;       // proportional divider code
  logic [2:0] ki_div;       // integral divider code
  logic [7:0] thr;          // exit frequency threshold
  assign adapt_en = regs_q[0][qdc_pkg::B_ADAPT];
  assign ss_en    = regs_q[2][qdc_pkg::B_EN];
  assign pwm_rate = regs_q[2][qdc_pkg::B_PWM +: 2];
  assign smpl_sel = regs_q[2][qdc_pkg::B_SMPL +: 2];
  assign kp       = regs_q[3][6:0];
  assign ki       = regs_q[4][6:0];
  assign kp_div   = regs_q[5][qdc_pkg::B_KP_DIV +: 3];
  assign ki_div   = regs_q[5][qdc_pkg::B_KI_DIV +: 3];
  assign thr      = regs_q[6];

  // divider code to shift; the unused code 111b acts as 000b
  function automatic logic [3:0] div_shift(input logic [2:0] code);
    case (code)
      3'h0:    div_shift = qdc_pkg::SH_32;
      3'h1:    div_shift = qdc_pkg::SH_64;
      3'h2:    div_shift = qdc_pkg::SH_128;
      3'h3:    div_shift = qdc_pkg::SH_256;
      3'h4:    div_shift = qdc_pkg::SH_512;
      3'h5:    div_shift = qdc_pkg::SH_16;
      3'h6:    div_shift = qdc_pkg::SH_NONE;
      default: div_shift = qdc_pkg::SH_32;
    endcase
  endfunction : div_shift

  // quiet decay holds while enabled and at or below the threshold
  logic ss_active_d;
  assign ss_active_d = ss_en && (SINE_FREQ <= {1'b0, thr});

  // pwm period length from rate code
  logic [8:0] pwm_last;
  assign pwm_last = (pwm_rate == 2'h0) ? 9'(qdc_pkg::PWM_CYC0 - 1) :
                    (pwm_rate == 2'h1) ? 9'(qdc_pkg::PWM_CYC1 - 1) :
                    (pwm_rate == 2'h2) ? 9'(qdc_pkg::PWM_CYC2 - 1) :
                                         9'(qdc_pkg::PWM_CYC3 - 1);

  // pwm period counter, idle at zero outside quiet decay
  logic [8:0] pwm_cnt_q;
  logic [8:0] pwm_cnt_d;
  logic       period_end;
  assign period_end = SS_ACTIVE && (pwm_cnt_q >= pwm_last);
  assign pwm_cnt_d  = (!SS_ACTIVE || period_end) ? 9'h000 : pwm_cnt_q + 9'h001;

  // zero cross sample window length from code
  logic [5:0] smpl_len;
  assign smpl_len = (smpl_sel == 2'h0) ? 6'(qdc_pkg::SMPL_CYC0) :
                    (smpl_sel == 2'h1) ? 6'(qdc_pkg::SMPL_CYC1) :
                    (smpl_sel == 2'h2) ? 6'(qdc_pkg::SMPL_CYC2) :
                                         6'(qdc_pkg::SMPL_CYC3);

  // window counter, a new crossing does not restart a running window
  logic [5:0] zc_cnt_q;
  logic [5:0] zc_cnt_d;
  assign zc_cnt_d = (zc_cnt_q != 6'h00) ? zc_cnt_q - 6'h01 :
                    (ZERO_CROSS && SS_ACTIVE) ? smpl_len : 6'h00;

  // pi loop: error, scaled terms, integrator and duty
  logic signed [8:0]  err;
  logic signed [16:0] p_prod;
  logic signed [16:0] i_prod;
  logic signed [16:0] p_term;
  logic signed [16:0] i_term;
  logic signed [11:0] integ_q;
  logic signed [17:0] integ_sum;
  logic signed [11:0] integ_d;
  logic signed [17:0] pi_sum;
  logic        [7:0]  duty_d;
  assign err    = $signed({1'b0, TARGET_I}) - $signed({1'b0, SENSE_I});
  assign p_prod = $signed({1'b0, kp}) * err;
  assign i_prod = $signed({1'b0, ki}) * err;
  assign p_term = p_prod >>> div_shift(kp_div);
  assign i_term = i_prod >>> div_shift(ki_div);
  assign integ_sum = 18'(integ_q) + 18'(i_term);
  // clamp integrator to keep it from winding up
  assign integ_d = (integ_sum > 18'(qdc_pkg::INTEG_MAX)) ? 12'(qdc_pkg::INTEG_MAX) :
                   (integ_sum < -18'(qdc_pkg::INTEG_MAX)) ? -12'(qdc_pkg::INTEG_MAX) :
                   integ_sum[11:0];
  assign pi_sum = 18'(p_term) + 18'(integ_q);
  assign duty_d = (pi_sum < 18'sh00000) ? 8'h00 :
                  (pi_sum > 18'(qdc_pkg::DUTY_MAX)) ? 8'(qdc_pkg::DUTY_MAX) : pi_sum[7:0];

  // bus read data and status outputs
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      RDATA     <= 8'h00;
      SS_ACTIVE <= 1'b0;
      RETUNE    <= 1'b0;
    end
    else
    begin
      RDATA     <= RD ? rdata_d : 8'h00;
      SS_ACTIVE <= ss_active_d;
      RETUNE    <= SUPPLY_CHG && adapt_en;
    end
  end

  // pwm timing and zero cross window
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pwm_cnt_q <= 9'h000;
      PWM_START <= 1'b0;
      zc_cnt_q  <= 6'h00;
      ZC_SAMPLE <= 1'b0;
    end
    else
    begin
      pwm_cnt_q <= pwm_cnt_d;
      PWM_START <= period_end;
      zc_cnt_q  <= zc_cnt_d;
      ZC_SAMPLE <= (zc_cnt_d != 6'h00);
    end
  end

  // pi state, duty changes only at period end or on leaving quiet decay
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      integ_q <= 12'sh000;
      DUTY    <= 8'h00;
    end
    else if (!SS_ACTIVE)
    begin
      integ_q <= 12'sh000;
      DUTY    <= 8'h00;
    end
    else if (period_end)
    begin
      integ_q <= integ_d;
      DUTY    <= duty_d;
    end
  end

  // checks
  property p_retune;
    @(posedge CLK) disable iff (!RSTN)
    SUPPLY_CHG |=> (RETUNE == $past(adapt_en));
  endproperty
  a_retune: assert property (p_retune) else $error("retune mismatch");

  property p_rw;
    @(posedge CLK) disable iff (!RSTN)
    (WR && ADDR >= 8'h31 && ADDR <= 8'h35) ##1 (RD && ADDR == $past(ADDR))
      |=> (RDATA == $past(WDATA, 2));
  endproperty
  a_rw: assert property (p_rw) else $error("readback mismatch");

  property p_smpl;
    @(posedge CLK) disable iff (!RSTN)
    (ZERO_CROSS && SS_ACTIVE && zc_cnt_q == 6'h00 && smpl_sel == 2'h0)
      |=> ZC_SAMPLE [*8] ##12 ZC_SAMPLE ##1 !ZC_SAMPLE;
  endproperty
  a_smpl: assert property (p_smpl) else $error("sample window short");

  property p_pwm;
    @(posedge CLK) disable iff (!RSTN)
    (SS_ACTIVE && pwm_rate == 2'h3 && pwm_cnt_q == 9'(qdc_pkg::PWM_CYC3 - 1)) |=> PWM_START;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm period wrong");

  property p_en;
    @(posedge CLK) disable iff (!RSTN)
    !ss_en |=> !SS_ACTIVE;
  endproperty
  a_en: assert property (p_en) else $error("active while disabled");

  property p_kp;
    @(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == 8'h32) |=> (kp == $past(WDATA[6:0]));
  endproperty
  a_kp: assert property (p_kp) else $error("kp not stored");

  property p_ki;
    @(posedge CLK) disable iff (!RSTN)
    (WR && ADDR == 8'h33) |=> (ki == $past(WDATA[6:0]));
  endproperty
  a_ki: assert property (p_ki) else $error("ki not stored");

  property p_kdiv;
    @(posedge CLK) disable iff (!RSTN)
    (kp_div == 3'h5 && err == 9'sh010) |-> (p_term == 17'(kp));
  endproperty
  a_kdiv: assert property (p_kdiv) else $error("kp divide wrong");

  property p_idiv;
    @(posedge CLK) disable iff (!RSTN)
    (ki_div == 3'h5 && err == 9'sh010) |-> (i_term == 17'(ki));
  endproperty
  a_idiv: assert property (p_idiv) else $error("ki divide wrong");

  property p_exit;
    @(posedge CLK) disable iff (!RSTN)
    (SINE_FREQ > {1'b0, thr}) |=> !SS_ACTIVE;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit above threshold");

  property p_duty;
    @(posedge CLK) disable iff (!RSTN)
    (SS_ACTIVE && !period_end) |=> $stable(DUTY);
  endproperty
  a_duty: assert property (p_duty) else $error("duty changed mid period");

  // read data stand for one cycle only, so a stale byte never lingers
  property p_rd_idle;
    @(posedge CLK) disable iff (!RSTN)
    !RD |=> (RDATA == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

  property p_zc_off;
    @(posedge CLK) disable iff (!RSTN)
    (ZERO_CROSS && !SS_ACTIVE && zc_cnt_q == 6'h00) |=> !ZC_SAMPLE;
  endproperty
  a_zc_off: assert property (p_zc_off) else $error("window opened while inactive");

  property p_pwm_off;
    @(posedge CLK) disable iff (!RSTN)
    !SS_ACTIVE |=> !PWM_START;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm pulse while inactive");

  // the loop is dropped outside quiet decay, so the bridge sees no stale duty
  property p_duty_off;
    @(posedge CLK) disable iff (!RSTN)
    !SS_ACTIVE |=> (DUTY == 8'h00);
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("duty while inactive");
endmodule : qdc_regs
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the quiet decay configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 16'(e), 16'(g))
module tb;
  logic       clk;          // bench clock, 100 ns period
  logic       rstn;         // synchronous reset, active low
  logic [7:0] addr;         // register address
  logic [7:0] wdata;        // write data
  logic       wr_s;         // write strobe
  logic       rd_s;         // read strobe
  logic [7:0] rdata;        // read data
  logic       supply_chg;   // supply change pulse
  logic       zero_cross;   // zero cross pulse
  logic [8:0] sine_freq;    // sine frequency, 2 Hz units
  logic [7:0] target_i;     // target current
  logic [7:0] sense_i;      // sensed current
  logic       retune;       // retune pulse
  logic       ss_active;    // quiet decay in force
  logic       pwm_start;    // pwm period start
  logic       zc_sample;    // zero cross window
  logic [7:0] duty;         // bridge duty
  int         err_total;    // mismatches seen
  int         total_checks; // comparisons made
  logic [7:0] rd_v;         // last read value
  logic [7:0] d1;           // earlier duty sample
  int         n;            // cycle count
  int         p;            // expected duty before clamp
  // rows of address, write data and expected read back
  localparam logic [23:0] ROWS [9] = '{24'h2F5A5A, 24'h30A5A5, 24'h31C3C3, 24'h327F7F,
                                       24'h338080, 24'h347777, 24'h350101, 24'h2E1200,
                                       24'h363400};
  // pwm rates in Hz for codes 0 to 3
  localparam int HZ [4] = '{25000, 33000, 42000, 50000};
  qdc_regs u_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .SUPPLY_CHG(supply_chg), .ZERO_CROSS(zero_cross), .SINE_FREQ(sine_freq),
    .TARGET_I(target_i), .SENSE_I(sense_i), .RETUNE(retune), .SS_ACTIVE(ss_active),
    .PWM_START(pwm_start), .ZC_SAMPLE(zc_sample), .DUTY(duty));
  // compare and count
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // one clock, then let outputs settle
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  // cycles up to the next pwm start pulse, bounded
  task automatic gap(output int cnt);
    cnt = 0;
    do
    begin
      tick();
      cnt++;
    end
    while (pwm_start !== 1'b1 && cnt < 600);
  endtask : gap
  // zero cross pulse, then width of the sampling window
  task automatic zc(output int cnt);
    @(posedge clk);
    zero_cross <= 1'b1;
    @(posedge clk);
    zero_cross <= 1'b0;
    #1;
    cnt = 0;
    while (zc_sample === 1'b1 && cnt < 100)
    begin
      cnt++;
      tick();
    end
  endtask : zc
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog, well beyond the expected run length
  initial
  begin
    #(30000 * 100);
    err_total++;
    $display("MISMATCH watchdog expected finish seen timeout");
    complete_run();
  end
  // main sequence
  initial
  begin
    {rstn, addr, wdata, wr_s, rd_s, supply_chg, zero_cross} = '0;
    sine_freq = 9'h010;
    target_i = 8'h30;
    sense_i = 8'h20;
    err_total = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK("duty_reset", 8'h00, duty);
    for (int i = 0; i < 7; i++)
    begin
      rd(8'h2F + 8'(i), rd_v);
      `CHK("reset_value", (i == 6) ? 8'hFF : 8'h00, rd_v);
    end
    $display("test reset done");
    // unmapped locations are only read, never written
    foreach (ROWS[i])
      if (ROWS[i][23:16] >= qdc_pkg::A_ADAPT && ROWS[i][23:16] <= qdc_pkg::A_THR)
        wr(ROWS[i][23:16], ROWS[i][15:8]);
    foreach (ROWS[i])
    begin
      rd(ROWS[i][23:16], rd_v);
      `CHK("readback", ROWS[i][7:0], rd_v);
    end
    // write then read with no gap between the strobes
    @(posedge clk);
    addr  <= qdc_pkg::A_KP;
    wdata <= 8'h15;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK("back_to_back", 8'h15, rdata);
    $display("test table done");
    wr(8'h2F, 8'h40);
    @(posedge clk) supply_chg <= 1'b1;
    @(posedge clk) supply_chg <= 1'b0;
    #1 `CHK("retune_on", 1'b1, retune);
    wr(8'h2F, 8'hBF);
    @(posedge clk) supply_chg <= 1'b1;
    @(posedge clk) supply_chg <= 1'b0;
    #1 `CHK("retune_off", 1'b0, retune);
    $display("test retune done");
    wr(8'h35, 8'h10);
    wr(8'h31, 8'h00);
    tick();
    tick();
    `CHK("active_off", 1'b0, ss_active);
    zc(n);
    `CHK("zc_inactive", 0, n);
    wr(8'h31, 8'h01);
    tick();
    tick();
    `CHK("active_on", 1'b1, ss_active);
    @(posedge clk) sine_freq <= 9'h011;
    tick();
    tick();
    `CHK("active_above", 1'b0, ss_active);
    @(posedge clk) sine_freq <= 9'h010;
    $display("test enable done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h31, 8'(c << 6) | 8'(c << 2) | 8'h01);
      tick();
      tick();
      zc(n);
      `CHK("zc_width", (2 + c) * qdc_pkg::CLK_MHZ, n);
      gap(n);
      gap(n);
      gap(n);
      `CHK("pwm_period", qdc_pkg::CLK_HZ / HZ[c], n);
    end
    $display("test timing done");
    wr(8'h31, 8'h0D);
    wr(8'h33, 8'h00);
    wr(8'h32, 8'h40);
    for (int c = 0; c < 7; c++)
    begin
      wr(8'h34, 8'(c));
      gap(n);
      gap(n);
      p = (c == 6) ? 1024 : (c == 5) ? 1024 / 16 : 1024 >> (5 + c);
      `CHK("duty_prop", (p > 255) ? 255 : p, duty);
    end
    wr(8'h32, 8'h00);
    wr(8'h34, 8'h50);
    wr(8'h33, 8'h40);
    gap(n);
    gap(n);
    d1 = duty;
    gap(n);
    `CHK("duty_integ_step", 8'h40, duty - d1);
    $display("test pi done");
    // reset in mid run, held two edges so no check sees a half reset
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    `CHK("duty_mid_reset", 8'h00, duty);
    `CHK("active_mid_reset", 1'b0, ss_active);
    rd(qdc_pkg::A_MAIN, rd_v);
    `CHK("main_mid_reset", 8'h00, rd_v);
    rd(qdc_pkg::A_THR, rd_v);
    `CHK("thr_mid_reset", 8'hFF, rd_v);
    $display("test mid reset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
